// ### design/asc_pkg.sv
// Purpose: shared constants of the converter control block
// Assumes: 40 MHz core clock, classic wishbone register port
// Notes: pin vector and config field positions are used by the top-level control block
package asc_pkg;
  // clock and conversion timing
  localparam int unsigned CLK_NS    = 25;
  localparam int unsigned T_CONV_NS = 1400;
  localparam int unsigned CONV_CYC  = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_HOLD_NS = 400;
  localparam logic [7:0]  CONV_LEN_RST = 8'(CONV_CYC);

  // synchronised pin vector positions
  localparam int unsigned PIN_W     = 12;
  localparam int unsigned PIN_GAIN  = 0;
  localparam int unsigned PIN_POL   = 1;
  localparam int unsigned PIN_A0    = 2;
  localparam int unsigned PIN_A2    = 4;
  localparam int unsigned PIN_PAIR  = 5;
  localparam int unsigned PIN_TRIG  = 6;
  localparam int unsigned PIN_CS    = 7;
  localparam int unsigned PIN_RD    = 8;
  localparam int unsigned PIN_LD    = 9;
  localparam int unsigned PIN_ML    = 10;
  localparam int unsigned PIN_MH    = 11;
  localparam logic [11:0] PINS_RST  = 12'h3c0;

  // config and entry layout: {pair, a2, a1, a0, polarity, gain}, entry adds last flag
  localparam int unsigned CFG_W     = 6;
  localparam int unsigned CFG_PAIR  = 5;
  localparam int unsigned ENT_W     = 7;
  localparam int unsigned SEQ_DEPTH = 16;
  localparam int unsigned DATA_W    = 12;

  // register map
  localparam logic [1:0]  REG_CTRL  = 2'h0;
  localparam logic [1:0]  REG_STAT  = 2'h1;
  localparam logic [1:0]  REG_RES   = 2'h2;
  localparam int unsigned STAT_CONV = 0;
  localparam int unsigned STAT_PROG = 1;
  localparam int unsigned STAT_MODE = 2;
  localparam int unsigned STAT_SCAN = 4;
  localparam int unsigned STAT_PTR  = 8;
  localparam int unsigned RES_ADDR  = 12;

  typedef enum logic [1:0] {
    ASC_DIRECT = 2'b00,
    ASC_SCAN   = 2'b01,
    ASC_PROG   = 2'b10,
    ASC_RUN    = 2'b11
  } asc_mode_t;
endpackage : asc_pkg

// ### design/asc_sync.sv
// Purpose: two-stage synchroniser for the pin inputs
// Assumes: inputs are asynchronous to core_clk_i
// Notes: only the second stage is visible outside
`timescale 1ns/10ps
module asc_sync (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // pins
  input  wire logic [11:0] pins_i,
  output logic      [11:0] pins_o
);
  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
  } asc_sync_t;

  asc_sync_t st;
  asc_sync_t next_st;

  always_comb
  begin
    next_st    = st;
    next_st.s1 = pins_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st <= {asc_pkg::PINS_RST, asc_pkg::PINS_RST};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pins_o = st.s2;
endmodule : asc_sync

// ### design/asc_seq_mem.sv
// Purpose: 16 x 7 sequence memory
// Assumes: one write, one flag clear and one read per cycle
// Notes: contents survive mode changes; read port is combinational
`timescale 1ns/10ps
module asc_seq_mem (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // write side
  input  wire logic       we_i,
  input  wire logic [3:0] waddr_i,
  input  wire logic [6:0] wdata_i,
  input  wire logic [3:0] caddr_i,
  // read side
  input  wire logic [3:0] raddr_i,
  output logic      [6:0] rdata_o
);
  typedef struct packed {
    logic [15:0][6:0] mem;
  } asc_mem_t;

  asc_mem_t st;
  asc_mem_t next_st;

  always_comb
  begin
    next_st = st;
    if (we_i)
    begin
      // the entry just before the write address loses its last flag
      next_st.mem[caddr_i][0] = 1'b0;
      next_st.mem[waddr_i]    = wdata_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata_o = st.mem[raddr_i];
endmodule : asc_seq_mem

// ### design/asc_top.sv
// Purpose: conversion start, output drive and channel sequencing control
// Assumes: pins synchronised here, sample value from same clock domain
// Notes: conversion length set by control register
// Overview of operation
// - selected trigger falling edge starts conversion
// - triggers ignored while a conversion runs
// - busy low for whole conversion
// - select and read low keep outputs driven
// - read high keeps outputs three-stated
// - old result shown, new on the same edge busy rises
// - direct mode uses pins, latched by load
// - scan mode uses counter, config still latched
// - single-ended scan walks channels 0 to 7
// - pair scan walks pairs 0-1 to 6-7
// - low mode bit toggle clears scan counter
// - scan advances by one or two, address output
// - sixteen seven-bit entries with last flag
// - program mode forces busy, blocks conversions
// - any mode bit change resets pointer
// - load rising edge stores entry, advances pointer
// - last written entry ends sequence, wraps after 16
// - readback drives status word on top pins
// - read rising edge three-states, advances pointer
// - lowest status bit marks sequence end
// - leaving program mode releases busy
// - run mode converts entries then returns to 0
// - output word holds result plus address
`timescale 1ns/10ps
module asc_top (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // control pins
  input  wire logic        sample_trigger_n_i,
  input  wire logic        device_select_n_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic        load_strobe_n_i,
  input  wire logic        operating_mode_high_bit_i,
  input  wire logic        operating_mode_low_bit_i,
  // address and config pins
  input  wire logic        pair_mode_select_i,
  input  wire logic        gain_range_select_i,
  input  wire logic        polarity_select_i,
  input  wire logic        mux_addr_bit2_i,
  input  wire logic        mux_addr_bit1_i,
  input  wire logic        mux_addr_bit0_i,
  // converter core
  input  wire logic [11:0] sample_value_i,
  output logic      [2:0]  mux_channel_o,
  output logic             mux_pair_o,
  output logic             mux_gain_o,
  output logic             mux_polarity_o,
  // output pins
  output logic             busy_n_o,
  output logic      [11:0] data_o,
  output logic             data_hi_oe_o,
  output logic             data_lo_oe_o,
  output logic             pair_flag_out_o,
  output logic             channel_bit2_out_o,
  output logic             channel_bit1_out_o,
  output logic             channel_bit0_out_o,
  output logic             addr_oe_o,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  typedef struct packed {
    logic [11:0] prev;
    logic [5:0]  cfg;
    logic        conv;
    logic [7:0]  cnt;
    logic [5:0]  ccfg;
    logic        c_scan;
    logic        c_run;
    logic        c_eos;
    logic [2:0]  scan;
    logic [3:0]  ptr;
    logic [11:0] result;
    logic [3:0]  res_addr;
    logic        busy_n;
    logic [11:0] dout;
    logic [3:0]  aout;
    logic        oe_a;
    logic        oe_hi;
    logic        oe_lo;
    logic [7:0]  conv_len;
    logic        ack;
    logic [31:0] rdat;
  } asc_state_t;

  asc_state_t  st;
  asc_state_t  next_st;
  logic [11:0] s;
  logic [6:0]  entry;
  logic        mem_we;
  asc_pkg::asc_mode_t mode;
  logic        mode_chg;
  logic        ml_chg;
  logic        start;
  logic        done;
  logic        rd_rise;
  logic        ld_rise;
  logic        prog;
  logic        rb_read;

  asc_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pins_i     ({operating_mode_high_bit_i, operating_mode_low_bit_i,
                  load_strobe_n_i, read_strobe_n_i, device_select_n_i,
                  sample_trigger_n_i, pair_mode_select_i, mux_addr_bit2_i,
                  mux_addr_bit1_i, mux_addr_bit0_i, polarity_select_i,
                  gain_range_select_i}),
    .pins_o     (s)
  );

  asc_seq_mem u_mem (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .we_i       (mem_we),
    .waddr_i    (st.ptr),
    .wdata_i    ({s[asc_pkg::CFG_W-1:0], 1'b1}),
    .caddr_i    (st.ptr - 4'h1),
    .raddr_i    (st.ptr),
    .rdata_o    (entry)
  );

  // edge and mode decode on synchronised pins
  always_comb
  begin
    mode     = asc_pkg::asc_mode_t'({s[asc_pkg::PIN_MH], s[asc_pkg::PIN_ML]});
    prog     = (mode == asc_pkg::ASC_PROG);
    ml_chg   = s[asc_pkg::PIN_ML] ^ st.prev[asc_pkg::PIN_ML];
    mode_chg = ml_chg | (s[asc_pkg::PIN_MH] ^ st.prev[asc_pkg::PIN_MH]);
    rd_rise  = s[asc_pkg::PIN_RD] & ~st.prev[asc_pkg::PIN_RD];
    ld_rise  = s[asc_pkg::PIN_LD] & ~st.prev[asc_pkg::PIN_LD];
    start    = ~s[asc_pkg::PIN_TRIG] & st.prev[asc_pkg::PIN_TRIG]
             & ~s[asc_pkg::PIN_CS] & ~st.conv & ~prog;
    done     = st.conv & (st.cnt == 8'h00);
    mem_we   = prog & ld_rise & s[asc_pkg::PIN_RD];
    rb_read  = prog & s[asc_pkg::PIN_LD] & ~s[asc_pkg::PIN_RD]
             & ~s[asc_pkg::PIN_CS];
  end

  always_comb
  begin
    next_st      = st;
    next_st.prev = s;
    next_st.ack  = wb_cyc_i & wb_stb_i & ~st.ack;
    next_st.rdat = 32'h0000_0000;

    // config follows pins while load low, held once it rises
    if (~s[asc_pkg::PIN_LD])
    begin
      next_st.cfg = s[asc_pkg::CFG_W-1:0];
    end

    // conversion start and run
    if (start)
    begin
      next_st.conv   = 1'b1;
      next_st.cnt    = st.conv_len - 8'h01;
      next_st.c_scan = (mode == asc_pkg::ASC_SCAN);
      next_st.c_run  = (mode == asc_pkg::ASC_RUN);
      next_st.c_eos  = entry[0];
      case (mode)
        asc_pkg::ASC_SCAN: next_st.ccfg = {next_st.cfg[5], st.scan,
                                           next_st.cfg[1:0]};
        asc_pkg::ASC_RUN:  next_st.ccfg = entry[6:1];
        default:           next_st.ccfg = next_st.cfg;
      endcase
    end
    else if (done)
    begin
      next_st.conv     = 1'b0;
      next_st.result   = sample_value_i;
      next_st.res_addr = st.ccfg[5:2];
    end
    else if (st.conv)
    begin
      next_st.cnt = st.cnt - 8'h01;
    end

    // scan counter
    if (ml_chg)
    begin
      next_st.scan = 3'h0;
    end
    else if (done & st.c_scan)
    begin
      next_st.scan = st.scan + (st.ccfg[asc_pkg::CFG_PAIR] ? 3'h2 : 3'h1);
    end

    // sequence pointer
    if (mode_chg)
    begin
      next_st.ptr = 4'h0;
    end
    else if (mem_we | (prog & s[asc_pkg::PIN_LD] & rd_rise))
    begin
      next_st.ptr = st.ptr + 4'h1;
    end
    else if (done & st.c_run)
    begin
      next_st.ptr = st.c_eos ? 4'h0 : st.ptr + 4'h1;
    end

    // busy held low by a conversion or by program mode
    next_st.busy_n = ~(next_st.conv | prog);

    // output drive
    if (prog)
    begin
      next_st.aout  = entry[6:3];
      next_st.dout  = {entry[2:0], 9'h000};
      next_st.oe_a  = rb_read;
      next_st.oe_hi = rb_read;
      next_st.oe_lo = 1'b0;
    end
    else
    begin
      next_st.aout  = next_st.res_addr;
      next_st.dout  = next_st.result;
      next_st.oe_a  = ~s[asc_pkg::PIN_CS] & ~s[asc_pkg::PIN_RD];
      next_st.oe_hi = next_st.oe_a;
      next_st.oe_lo = next_st.oe_a;
    end

    // register port
    if (wb_cyc_i & wb_stb_i & ~st.ack)
    begin
      if (wb_we_i & wb_sel_i[0] & (wb_adr_i[3:2] == asc_pkg::REG_CTRL)
          & (wb_adr_i[7:4] == 4'h0))
      begin
        // zero length would wrap the count to 255 and run 256 cycles
        next_st.conv_len = (wb_dat_i[7:0] == 8'h00) ? 8'h01 : wb_dat_i[7:0];
      end
      if (~wb_we_i & (wb_adr_i[7:4] == 4'h0))
      begin
        case (wb_adr_i[3:2])
          asc_pkg::REG_CTRL: next_st.rdat[7:0] = st.conv_len;
          asc_pkg::REG_STAT:
          begin
            next_st.rdat[asc_pkg::STAT_CONV]     = st.conv;
            next_st.rdat[asc_pkg::STAT_PROG]     = prog;
            next_st.rdat[asc_pkg::STAT_MODE+:2]  = mode;
            next_st.rdat[asc_pkg::STAT_SCAN+:3]  = st.scan;
            next_st.rdat[asc_pkg::STAT_PTR+:4]   = st.ptr;
          end
          asc_pkg::REG_RES:
          begin
            next_st.rdat[11:0]                  = st.result;
            next_st.rdat[asc_pkg::RES_ADDR+:4]  = st.res_addr;
          end
          default: next_st.rdat = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st          <= '0;
      st.prev     <= asc_pkg::PINS_RST;
      st.busy_n   <= 1'b1;
      st.conv_len <= asc_pkg::CONV_LEN_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign busy_n_o           = st.busy_n;
  assign data_o             = st.dout;
  assign data_hi_oe_o       = st.oe_hi;
  assign data_lo_oe_o       = st.oe_lo;
  assign pair_flag_out_o    = st.aout[3];
  assign channel_bit2_out_o = st.aout[2];
  assign channel_bit1_out_o = st.aout[1];
  assign channel_bit0_out_o = st.aout[0];
  assign addr_oe_o          = st.oe_a;
  assign mux_channel_o      = st.ccfg[4:2];
  assign mux_pair_o         = st.ccfg[5];
  assign mux_polarity_o     = st.ccfg[1];
  assign mux_gain_o         = st.ccfg[0];
  assign wb_dat_o           = st.rdat;
  assign wb_ack_o           = st.ack;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_start;
    start |=> st.conv && !busy_n_o;
  endproperty
  a_start: assert property (p_start) else $error("start missed");

  property p_no_restart;
    st.conv && !done |=> st.cnt == $past(st.cnt) - 8'h01;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart");

  property p_busy_end;
    done |=> busy_n_o == !prog && st.result == $past(sample_value_i);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy end");

  property p_busy_low;
    st.conv |-> !busy_n_o;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy high");

  property p_tristate;
    !prog && s[asc_pkg::PIN_RD] |=> !data_lo_oe_o && !addr_oe_o;
  endproperty
  a_tristate: assert property (p_tristate) else $error("driven");

  property p_prog_busy;
    prog |=> !busy_n_o && !st.conv;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("prog busy");

  property p_ptr_clr;
    mode_chg |=> st.ptr == 4'h0;
  endproperty
  a_ptr_clr: assert property (p_ptr_clr) else $error("ptr clr");

  property p_scan_clr;
    ml_chg |=> st.scan == 3'h0;
  endproperty
  a_scan_clr: assert property (p_scan_clr) else $error("scan clr");

  property p_rb_adv;
    prog && s[asc_pkg::PIN_LD] && rd_rise && !mode_chg
      |=> st.ptr == $past(st.ptr) + 4'h1 && !data_hi_oe_o;
  endproperty
  a_rb_adv: assert property (p_rb_adv) else $error("rb adv");

  property p_rb_pins;
    rb_read |=> data_hi_oe_o && addr_oe_o && !data_lo_oe_o;
  endproperty
  a_rb_pins: assert property (p_rb_pins) else $error("rb pins");

  c_run:  cover property (done && st.c_run);
  c_scan: cover property (done && st.c_scan);
  c_prog: cover property (mem_we);
  c_rb:   cover property (rb_read ##1 rd_rise);
endmodule : asc_top

// ### test/asc_host.sv
// Purpose: host bus model driving the converter pins
// Assumes: pins move just after a rising edge
// Notes: waits cover the pin synchroniser lag
`timescale 1ns/10ps
module asc_host (
  // clock and status
  input  wire logic       clk_i,
  input  wire logic       busy_n_i,
  // pins
  output logic            trig_n_o,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            ld_n_o,
  output logic [1:0]      mode_o,
  output logic [5:0]      cfg_o
);
  initial
  begin
    {trig_n_o, cs_n_o, rd_n_o, ld_n_o} = 4'hf;
    mode_o = 2'h0;
    cfg_o = 6'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step
  task automatic pins(input logic cs, input logic rd);
    {cs_n_o, rd_n_o} <= {cs, rd};
    step(4);
  endtask : pins
  task automatic set_mode(input logic [1:0] m);
    mode_o <= m;
    step(5);
  endtask : set_mode
  task automatic load(input logic [5:0] c);
    cfg_o <= c;
    ld_n_o <= 1'b0;
    step(4);
    ld_n_o <= 1'b1;
    step(2);
    // config pins no longer valid once latched
    cfg_o <= ~c;
    step(3);
  endtask : load
  task automatic trigger(output bit ok);
    int k;
    k = 0;
    trig_n_o <= 1'b0;
    @(posedge clk_i);
    // release well before the conversion could reach its sampling point
    trig_n_o <= 1'b1;
    do @(negedge clk_i); while (busy_n_i !== 1'b0 && ++k < 12);
    ok = (busy_n_i === 1'b0);
    @(posedge clk_i);
  endtask : trigger
  task automatic poke;
    // falls so that the synced edge lands in the last converting cycle
    trig_n_o <= 1'b0;
    step(1);
    trig_n_o <= 1'b1;
  endtask : poke
endmodule : asc_host

// ### test/asc_top_tb_top.sv
// Purpose: self-checking bench of the converter control block
// Assumes: conversion length set to 4 cycles over wishbone
// Notes: sequence entries modelled in a queue
`timescale 1ns/10ps
module asc_top_tb_top;
  localparam logic [7:0] LEN = 8'h04;
  logic        clk, rst, trig_n, cs_n, rd_n, ld_n, busy_n, hi_oe, lo_oe, a_oe;
  logic        pf, c2, c1, c0, pair, gain, pol, cyc, stb, we, ack;
  logic [1:0]  mode;
  logic [5:0]  cfg;
  logic [2:0]  mch;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [11:0] sample, data, prev;
  logic [31:0] wdat, rdat, q;
  logic [5:0]  seq[$];
  bit          ok;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;

  asc_host host (.clk_i(clk), .busy_n_i(busy_n), .trig_n_o(trig_n), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .ld_n_o(ld_n), .mode_o(mode), .cfg_o(cfg));
  asc_top uut (.core_clk_i(clk), .rst_i(rst), .sample_trigger_n_i(trig_n),
    .device_select_n_i(cs_n), .read_strobe_n_i(rd_n), .load_strobe_n_i(ld_n),
    .operating_mode_high_bit_i(mode[1]), .operating_mode_low_bit_i(mode[0]),
    .pair_mode_select_i(cfg[5]), .gain_range_select_i(cfg[0]), .polarity_select_i(cfg[1]),
    .mux_addr_bit2_i(cfg[4]), .mux_addr_bit1_i(cfg[3]), .mux_addr_bit0_i(cfg[2]),
    .sample_value_i(sample), .mux_channel_o(mch), .mux_pair_o(pair), .mux_gain_o(gain),
    .mux_polarity_o(pol), .busy_n_o(busy_n), .data_o(data), .data_hi_oe_o(hi_oe),
    .data_lo_oe_o(lo_oe), .pair_flag_out_o(pf), .channel_bit2_out_o(c2),
    .channel_bit1_out_o(c1), .channel_bit0_out_o(c0), .addr_oe_o(a_oe), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));

  task automatic wrap_up;
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    // reads carry random data and lanes, which the slave must ignore
    {cyc, stb, we, adr} <= {1'b1, 1'b1, w, a};
    wdat <= w ? d : $urandom;
    sel <= w ? s : 4'($urandom);
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    chk("wb_ack", 1, ack);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic conv(input logic [5:0] e, input bit rt);
    int n;
    sample <= 12'($urandom);
    host.trigger(ok);
    chk("start", 1, ok);
    if (rt) fork host.poke(); join_none
    n = 1;
    @(negedge clk);
    if (!rd_n && !cs_n) chk("old_data", prev, data);
    while (busy_n === 1'b0 && n < 300)
    begin
      n++;
      @(negedge clk);
    end
    chk("busy_len", LEN, n);
    chk("data", sample, data);
    chk("addr", e[5:2], {pf, c2, c1, c0});
    chk("mux", e, {pair, mch, pol, gain});
    chk("oe", {3{~(rd_n | cs_n)}}, {hi_oe, lo_oe, a_oe});
    prev = sample;
    repeat (6) @(negedge clk);
    chk("no_restart", 1, busy_n);
  endtask : conv

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  initial
  begin
    logic [5:0] c;
    logic [7:0] r;
    rst = 1'b1;
    {cyc, stb, we, adr, wdat, sel} = '0;
    sample = 12'h000;
    prev = 12'h000;
    void'($urandom(76));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("busy_rst", 1, busy_n);
    chk("oe_rst", 0, {hi_oe, lo_oe, a_oe});
    wb(1, 8'h0c, $urandom, 4'hf);
    wb(1, 8'h00, $urandom, 4'h0);
    wb(0, 8'h00, 32'h0, 4'hf);
    chk("ctrl_rst", {24'h0, asc_pkg::CONV_LEN_RST}, q);
    wb(0, 8'h0c, 32'h0, 4'hf);
    chk("unmapped", 32'h0, q);
    r = 8'($urandom);
    wb(1, 8'h00, {24'($urandom), r}, 4'h1);
    wb(0, 8'h00, 32'h0, 4'hf);
    chk("ctrl_wr", (r == 8'h00) ? 32'h1 : {24'h0, r}, q);
    wb(1, 8'h00, 32'(LEN), 4'hf);
    // direct mode, latched config, outputs off then driven
    host.pins(0, 1);
    c = 6'($urandom);
    host.load(c);
    conv(c, 1);
    host.pins(1, 1);
    host.trigger(ok);
    chk("unselected", 0, ok);
    host.pins(0, 0);
    c = 6'($urandom);
    host.load(c);
    conv(c, 0);
    wb(0, 8'h08, 32'h0, 4'hf);
    chk("result", {16'h0, c[5:2], prev}, q);
    // scan mode, single-ended then pairs
    host.pins(0, 1);
    host.set_mode(2'b01);
    host.load(6'h1c);
    for (int i = 0; i < 9; i++) conv({1'b0, 3'(i), 2'b00}, 0);
    host.set_mode(2'b00);
    host.set_mode(2'b01);
    host.load(6'h3f);
    for (int i = 0; i < 5; i++) conv({1'b1, 3'(2 * i), 2'b11}, 0);
    // program three entries
    host.set_mode(2'b10);
    chk("prog_busy", 0, busy_n);
    repeat (3)
    begin
      c = 6'($urandom);
      seq.push_back(c);
      host.load(c);
    end
    host.trigger(ok);
    wb(0, 8'h04, 32'h0, 4'hf);
    chk("prog_stat", 32'h30a, q & 32'hf0f);
    host.set_mode(2'b00);
    host.set_mode(2'b10);
    for (int i = 0; i < 4; i++)
    begin
      c = (i < 3) ? seq[i] : 6'h00;
      host.pins(0, 0);
      chk("status", {c, i == 2}, {pf, c2, c1, c0, data[11:9]});
      chk("rb_oe", 3'b101, {hi_oe, lo_oe, a_oe});
      host.pins(0, 1);
      chk("rb_off", 3'b000, {hi_oe, lo_oe, a_oe});
    end
    // run the programmed sequence past its end
    host.set_mode(2'b11);
    chk("run_busy", 1, busy_n);
    for (int i = 0; i < 4; i++) conv(seq[i % 3], 0);
    wrap_up();
  end
endmodule : asc_top_tb_top
